// File: bench/sbd_drop_irq_assertions.sv
`default_nettype none
// A shadow of the mask bit lets the interrupt be judged from the ports alone.
module sbd_drop_irq_checker (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic reg_rd_in,
  input wire logic reg_wr_in,
  input wire logic drop_in,
  input wire logic irq_out,
  input wire logic [15:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic [3:0] drop_cause_in,
  input wire logic [1:0] drop_port_in
);
  logic m_reg;
  wire logic mw = reg_wr_in && reg_addr_in == 16'h1c20;
  wire logic r = reg_rd_in && reg_addr_in == 16'h1c21 && !drop_in;
  wire logic d = drop_in && !reg_rd_in;
  wire logic [5:0] cp = {drop_cause_in, drop_port_in};
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
    if (!reset_n_in)
      m_reg <= 1'h1;
    else if (mw)
      m_reg <= reg_wdata_in[0];
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_a; r ##1 d ##1 r; endsequence
  sequence s_b; r ##1 d [*3] ##1 r; endsequence
  sequence s_m; r ##1 d ##1 mw && !drop_in && !reg_rd_in ##1 r; endsequence
  property p_msk; m_reg |-> !irq_out; endproperty
  a_msk: assert property (p_msk) else $error("irq while masked");
  property p_irq; !m_reg && d && !mw |=> irq_out; endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  property p_clr; r |=> !irq_out; endproperty
  a_clr: assert property (p_clr) else $error("read did not clear");
  property p_a; s_a |=> reg_rdata_out[13:0] == {7'h0, $past(cp, 2), 1'h1}; endproperty
  a_a: assert property (p_a) else $error("record a wrong");
  property p_b; s_b |=> reg_rdata_out[13:0] == {$past(cp, 3), 1'h1, $past(cp, 4), 1'h1};
  endproperty
  a_b: assert property (p_b) else $error("records wrong");
  property p_m; s_m |=> reg_rdata_out[6:0] == {$past(cp, 3), 1'h1}; endproperty
  a_m: assert property (p_m) else $error("mask write hit status");
  property p_mr; reg_rd_in && reg_addr_in == 16'h1c20 && !mw
    |=> reg_rdata_out == {31'h0, m_reg}; endproperty
  a_mr: assert property (p_mr) else $error("mask read wrong");
  property p_rw; reg_rd_in && reg_addr_in == 16'h1c21 && drop_in && !m_reg && !mw |=> irq_out;
  endproperty
  a_rw: assert property (p_rw) else $error("drop lost at read");
  property p_un; reg_rd_in && reg_addr_in[15:1] != 15'he10 |=> reg_rdata_out == 32'h0;
  endproperty
  a_un: assert property (p_un) else $error("unmapped read");
endmodule // sbd_drop_irq_checker
bind sbd_drop_irq sbd_drop_irq_checker u_chk (
  .clk_sys_in(clk_sys_in),
  .reset_n_in(reset_n_in),
  .reg_rd_in(reg_rd_in),
  .reg_wr_in(reg_wr_in),
  .drop_in(drop_in),
  .irq_out(irq_out),
  .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out),
  .drop_cause_in(drop_cause_in),
  .drop_port_in(drop_port_in)
);
`default_nettype wire

// File: bench/tb_sbd_drop_irq.sv
`default_nettype none
module tb_sbd_drop_irq;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 0, reset_n_in = 0, reg_rd_in = 0, reg_wr_in = 0, drop_in = 0, irq_out;
  logic [15:0] reg_addr_in = '0;
  logic [31:0] reg_wdata_in = '0, reg_rdata_out;
  logic [5:0] cp = '0;
  int n_fail = 0, cmp_count = 0;
  sbd_drop_irq dut
  (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .reg_rd_in(reg_rd_in),
    .reg_wr_in(reg_wr_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out),
    .drop_in(drop_in),
    .drop_cause_in(cp[5:2]),
    .drop_port_in(cp[1:0]),
    .irq_out(irq_out)
  );
  initial forever #12.5 clk_sys_in = ~clk_sys_in;
  // One cycle with strobes {read, write, drop}; v also carries {cause, port}.
  task automatic op(input logic [2:0] s, input logic [15:0] a, input logic [31:0] v);
    {reg_rd_in, reg_wr_in, drop_in} = s;
    reg_addr_in = a;
    reg_wdata_in = v;
    cp = v[5:0];
    @(negedge clk_sys_in);
  endtask
  task automatic chk(input logic [31:0] g, e);
    cmp_count++;
    n_fail += int'(g !== e);
    if (g !== e) $display("[FAIL] %0t got %h want %h", $time, g, e);
  endtask
  task automatic t_basic;
    logic [3:0] c[8] = '{0, 1, 2, 3, 4, 5, 6, 9};
    op(3'h4, 16'h1c20, 0);
    chk(reg_rdata_out, 1);
    op(3'h2, 16'h1c21, 32'h3fff);
    op(3'h4, 16'h1234, 0);
    chk(reg_rdata_out | irq_out, 0);
    op(3'h2, 16'h1c20, 0);
    for (int i = 0; i < 8; i++)
    begin
      op(3'h1, 0, {c[i], 2'(i % 3)});
      chk(irq_out, 1);
      op(3'h4, 16'h1c21, 0);
      chk(reg_rdata_out, {c[i], 2'(i % 3), 1'h1});
      chk(irq_out, 0);
    end
    $display("t_basic done");
  endtask
  // Three drops back to back: the third finds both records full and is lost.
  task automatic t_two;
    op(3'h1, 0, 6'h26);
    op(3'h1, 0, 6'h15);
    op(3'h1, 0, 6'h18);
    op(3'h4, 16'h1c21, 0);
    chk(reg_rdata_out, 32'h15cd);
    op(3'h1, 0, 6'h09);
    op(3'h2, 16'h1c20, 1);
    chk(irq_out, 0);
    op(3'h4, 16'h1c21, 0);
    chk(reg_rdata_out, 32'h13);
    $display("t_two done");
  endtask
  // A drop meeting the clearing read is kept in A and shows at the next read.
  task automatic t_race;
    op(3'h2, 16'h1c20, 0);
    op(3'h1, 0, 6'h0e);
    op(3'h5, 16'h1c21, 6'h19);
    chk(reg_rdata_out, 32'h1d);
    chk(irq_out, 1);
    op(3'h4, 16'h1c21, 0);
    chk(reg_rdata_out, 32'h33);
    chk(irq_out, 0);
    $display("t_race done");
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(negedge clk_sys_in);
    reset_n_in = 1;
    t_basic();
    t_two();
    t_race();
    final_report();
  end
  // The tests need about 36 cycles; 400 means a hang.
  initial
  begin
    repeat (400) @(posedge clk_sys_in);
    n_fail++;
    final_report();
  end
endmodule // tb_sbd_drop_irq
`default_nettype wire

// File: rtl/sbd_drop_irq.v
`default_nettype none
`include "sbd_map.vh"
module sbd_drop_irq
(
  input wire clk_sys_in,
  input wire reset_n_in,
  input wire reg_rd_in,
  input wire reg_wr_in,
  input wire [15:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  output wire [31:0] reg_rdata_out,
  input wire drop_in,
  input wire [3:0] drop_cause_in,
  input wire [1:0] drop_port_in,
  output wire irq_out
);
  reg mask_reg; // Interrupt mask, set from reset.
  reg mask_next; // Next value of the mask flop.
  reg [31:0] rdata_reg; // Read data captured on a read strobe.
  reg [31:0] rdata_next; // Next value of the read data flop.
  reg [31:0] pend_word; // Assembled pending register, reserved bits zero.
  reg load_a; // Drop goes to record A.
  reg load_b; // Drop goes to record B.
  wire a_valid; // Record A occupied.
  wire b_valid; // Record B occupied.
  wire [3:0] a_cause; // Cause code held in record A.
  wire [1:0] a_port; // Ingress port held in record A.
  wire [3:0] b_cause; // Cause code held in record B.
  wire [1:0] b_port; // Ingress port held in record B.
  wire mask_sel; // Bus index points at the mask register.
  wire pend_sel; // Bus index points at the pending register.
  wire mask_write; // Write strobe aimed at the mask register.
  wire mask_read; // Read strobe aimed at the mask register.
  wire pend_read; // Clearing read of the pending register.
  wire any_valid; // At least one record waits for software.

  // Compares a bus index with one register index. The same decode serves the
  // write path, the read path and the clearing read, so it is kept in one place.
  function addr_hit;
    input [15:0] addr;
    input [15:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // Packs one record into its seven-bit slot: cause above port above valid.
  // Both records share this layout, so A and B cannot drift apart.
  function [6:0] pack_record;
    input valid;
    input [1:0] port;
    input [3:0] cause;
    begin
      pack_record = {cause, port, valid};
    end
  endfunction

  // Register decode. Every access is a one-cycle strobe, so the decode needs no state.
  assign mask_sel = addr_hit(reg_addr_in, `SBD_ADDR_MASK);
  assign pend_sel = addr_hit(reg_addr_in, `SBD_ADDR_PEND);
  assign mask_write = reg_wr_in && mask_sel;
  assign mask_read = reg_rd_in && mask_sel;
  // Writes to the pending register are not decoded: its fields change only by
  // capture and by the clearing read.
  assign pend_read = reg_rd_in && pend_sel;

  // Record steering. Record A fills first and B takes a drop only while A is
  // occupied, so two separate drops are kept until software reads.
  // With both records full a further drop is discarded unless it meets the clearing read: overwriting would destroy
  // a record that software has not yet seen, and the older pair is worth more.
  always @*
  begin
    load_a = 1'h0;
    load_b = 1'h0;
    if (drop_in)
    begin
      if (pend_read)
      begin
        // The read empties both records at this edge, so the drop goes to A
        // and is reported by the next read; the set wins over the clear.
        load_a = 1'h1;
      end
      else
      begin
        case ({a_valid, b_valid})
          2'h0:
          begin
            // Both records empty: the drop opens record A.
            load_a = 1'h1;
          end
          2'h2:
          begin
            // Record A occupied and B free: the drop goes to B.
            load_b = 1'h1;
          end
          2'h3:
          begin
            // Both records occupied: the drop is lost until software reads.
            load_b = 1'h0;
          end
          default:
          begin
            // B full with A empty cannot arise, as both clear together; refill A.
            load_a = 1'h1;
          end
        endcase
      end
    end
  end

  // Record A, bits 6:0.
  sbd_record rec_a
  (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .load_in(load_a),
    .clear_in(pend_read),
    .cause_in(drop_cause_in), // Codes are kept as given.
    .port_in(drop_port_in),
    .valid_out(a_valid),
    .cause_out(a_cause),
    .port_out(a_port)
  );

  // Record B, bits 13:7.
  sbd_record rec_b
  (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .load_in(load_b),
    .clear_in(pend_read),
    .cause_in(drop_cause_in),
    .port_in(drop_port_in),
    .valid_out(b_valid),
    .cause_out(b_cause),
    .port_out(b_port)
  );

  // Pending word: record A in bits 6:0, record B in bits 13:7, reserved bits
  // 31:14 zero. The slots come from the field-position constants.
  always @*
  begin
    pend_word = 32'h00000000;
    // Record A: valid at bit 0, port at 2:1, cause at 6:3.
    pend_word[`SBD_A_CAUSE_HI:`SBD_A_VALID] = pack_record(a_valid, a_port, a_cause);
    // Record B: valid at bit 7, port at 9:8, cause at 13:10.
    pend_word[`SBD_B_CAUSE_HI:`SBD_B_VALID] = pack_record(b_valid, b_port, b_cause);
  end

  // Mask next value. Only a mask write reaches this flop; the records have their
  // own load and clear terms, so masking never alters what was recorded.
  always @*
  begin
    mask_next = mask_reg;
    if (mask_write)
    begin
      // Bits 31:1 of the written word are reserved and ignored.
      mask_next = reg_wdata_in[`SBD_MASK_BIT];
    end
  end

  // Mask flop. Reset leaves the interrupt masked until software opens it.
  always @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      mask_reg <= `SBD_MASK_RESET;
    end
    else
    begin
      mask_reg <= mask_next;
    end
  end

  // Read data next value. The pending word is taken before the clear lands, so a
  // read returns what the records held at its strobe edge.
  always @*
  begin
    rdata_next = rdata_reg;
    if (pend_read)
    begin
      rdata_next = pend_word;
    end
    else if (mask_read)
    begin
      // Reserved mask bits read as zero.
      rdata_next = {31'h00000000, mask_reg};
    end
    else if (reg_rd_in)
    begin
      // Unmapped indexes read as zero rather than as stale data.
      rdata_next = 32'h00000000;
    end
  end

  // Read data flop. It holds between reads, so software may pick it up late.
  always @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_out = rdata_reg;

  // Any record still waiting for software keeps the request alive.
  assign any_valid = a_valid || b_valid;
  // The interrupt is a level; the mask gates only this output. Being built from
  // flops it has no glitches, and it follows a mask write one cycle later.
  assign irq_out = any_valid && !mask_reg;
endmodule // sbd_drop_irq
`default_nettype wire

// File: rtl/sbd_map.vh
`ifndef SBD_MAP_VH
`define SBD_MAP_VH
// Register indexes of the block (word addresses within the switch register space).
`define SBD_ADDR_MASK 16'h1c20
`define SBD_ADDR_PEND 16'h1c21
// Mask register field and reset value.
`define SBD_MASK_BIT 0
`define SBD_MASK_RESET 1'h1
// Pending register field positions.
`define SBD_A_VALID 0
`define SBD_A_PORT_LO 1
`define SBD_A_PORT_HI 2
`define SBD_A_CAUSE_LO 3
`define SBD_A_CAUSE_HI 6
`define SBD_B_VALID 7
`define SBD_B_PORT_LO 8
`define SBD_B_PORT_HI 9
`define SBD_B_CAUSE_LO 10
`define SBD_B_CAUSE_HI 13
// Drop cause codes.
`define SBD_CAUSE_BCAST_LEVEL 4'h0
`define SBD_CAUSE_RED 4'h1
`define SBD_CAUSE_NO_BUFFER 4'h2
`define SBD_CAUSE_NO_DESC 4'h3
`define SBD_CAUSE_NO_DEST 4'h4
`define SBD_CAUSE_RX_ERROR 4'h5
`define SBD_CAUSE_DROP_LEVEL 4'h6
`define SBD_CAUSE_YELLOW 4'h9
// Port encodings.
`define SBD_PORT_0 2'h0
`define SBD_PORT_1 2'h1
`define SBD_PORT_2 2'h2
`define SBD_PORT_RSVD 2'h3
`endif

// File: rtl/sbd_record.v
`default_nettype none
`include "sbd_map.vh"
// One drop record: a valid flag with cause and port fields, cleared by a read.
module sbd_record
(
  input wire clk_sys_in,
  input wire reset_n_in,
  input wire load_in,
  input wire clear_in,
  input wire [3:0] cause_in,
  input wire [1:0] port_in,
  output wire valid_out,
  output wire [3:0] cause_out,
  output wire [1:0] port_out
);
  reg valid_reg; // Record holds a captured drop.
  reg [3:0] cause_reg; // Captured drop cause.
  reg [1:0] port_reg; // Captured ingress port.

  // A load in the same cycle as the clearing read wins, so no drop is lost.
  always @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      valid_reg <= 1'h0;
      cause_reg <= 4'h0;
      port_reg <= 2'h0;
    end
    else if (load_in)
    begin
      valid_reg <= 1'h1;
      cause_reg <= cause_in;
      port_reg <= port_in;
    end
    else if (clear_in)
    begin
      valid_reg <= 1'h0;
      cause_reg <= 4'h0;
      port_reg <= 2'h0;
    end
  end

  assign valid_out = valid_reg;
  assign cause_out = cause_reg;
  assign port_out = port_reg;
endmodule // sbd_record
`default_nettype wire
